/* File: design/link_tx_pkg.sv */
// Purpose: Shared constants for the serial converter link transmitter.
// Assumes: One octet per lane per clock before line encoding.
// Notes: Character codes are the standard control characters of the link.
package link_tx_pkg;

  // ==========================================================================
  // Sizes
  localparam int MAX_LANES = 16;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int MF_LEN_W = 10;
  localparam int BLOCK_OCTETS = 8;
  localparam int ILAS_MULTIFRAMES = 4;

  // ==========================================================================
  // Control characters and headers
  localparam logic [7:0] CHAR_COMMA = 8'hbc;
  localparam logic [7:0] CHAR_MF_START = 8'h1c;
  localparam logic [7:0] CHAR_MF_END = 8'h7c;
  localparam logic [7:0] CHAR_IDLE = 8'h00;
  localparam logic [1:0] HDR_DATA = 2'h1;

  // ==========================================================================
  // Counter values after reset and at their last step
  localparam logic [MF_LEN_W-1:0] LMFC_CNT_RST = 10'h000;
  localparam logic [1:0] ILAS_MF_RST = 2'h0;
  localparam logic [1:0] ILAS_MF_LAST = 2'h3;
  localparam logic [2:0] BLOCK_LAST = 3'h7;

  // ==========================================================================
  // Link states
  typedef enum logic [1:0] {
    ST_CGS,
    ST_WAIT_LMFC,
    ST_ILAS,
    ST_DATA
  } link_state_t;

endpackage : link_tx_pkg

/* File: design/sample_fifo.sv */
// Purpose: Small flop-based FIFO between the sample source and the lanes.
// Assumes: Single clock; push and pop may occur in the same cycle.
// Notes: in_ready low means full; out_valid low means empty.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("sample_fifo: DEPTH must be a power of two of at least 2.");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // ==========================================================================
  // Flags come straight from the occupancy count, so they never lie.
  assign in_ready = (count_r != (AW + 1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // Storage has no reset; only pointers and count need a defined value.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointer and count update.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : sample_fifo

/* File: design/serial_converter_link_tx.sv */
// Purpose: Link layer of the converter's serial transmit path, per-lane octets.
// Assumes: clk is the device clock; sync_n and sysref are asynchronous pins.
// Notes: Line encoding and serialisation follow this block, outside it.
`timescale 1ns/1ps

// Overview of operation
// - Up to sixteen lanes; more lanes used means lower rate per lane.
// - Each lane runs either 8B/10B or 64B/66B coding, chosen by configuration.
// - 8B/10B has a physical sync input; receiver pulls it low to start.
// - 64B/66B aligns blocks from embedded sync headers, not from sync.
// - 64B/66B ignores sync for link start; may use it for oscillator sync.
// - One device clock drives sampling, digital logic and serializers.
// - System reference resets multiframe or extended multiblock counter phase.
// - Forward error correction is supported in 64B/66B mode.
// - The three-bit check option of 64B link layers is never generated.
// - No command channel and no 64B/80B link layer.
// - Subclass 1 transmitter only, usable by subclass 0 receivers.
// - Lanes of one link align; no multipoint alignment reference.
// - Sync handshake timing suits both earlier link revisions.
// - 8B/10B operation stays compatible with the earlier link revision.
// - In 8B/10B, sync low makes every lane below lanes_used send continuous comma characters.
// - After sync rises, wait for next multiframe edge, then alignment sequence.
module serial_converter_link_tx
  import link_tx_pkg::*;
#(
  parameter int LANES = MAX_LANES,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic sysref,
  input wire logic mode_64b,
  input wire logic fec_en,
  input wire logic [4:0] lanes_used,
  input wire logic [MF_LEN_W-1:0] mf_len,
  input wire logic [LANES*8-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [LANES*8-1:0] lane_octet,
  output logic [LANES-1:0] lane_is_k,
  output logic [LANES-1:0] lane_en,
  output logic hdr_valid,
  output logic [1:0] hdr,
  output logic [LANES*8-1:0] fec_parity,
  output logic fec_valid,
  output logic link_up,
  output logic lmfc_edge,
  output logic nco_sync
);

  initial begin
    if (LANES < 1 || LANES > MAX_LANES) begin
      $error("serial_converter_link_tx: LANES must be 1 to 16.");
    end
  end

  // ==========================================================================
  // Pin synchronisers
  // Each pin passes two flops; a third stage gives the previous level for
  // edge detection, so nothing ever looks at the first flop.
  logic [1:0] sync_sh_r;
  logic [1:0] sref_sh_r;
  logic sync_d_r;
  logic sref_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_sh_r <= 2'h3;
      sref_sh_r <= 2'h0;
      sync_d_r <= 1'b1;
      sref_d_r <= 1'b0;
    end else begin
      sync_sh_r <= {sync_sh_r[0], sync_n};
      sref_sh_r <= {sref_sh_r[0], sysref};
      sync_d_r <= sync_sh_r[1];
      sref_d_r <= sref_sh_r[1];
    end
  end

  // Level-sensitive request and edge events from the synchronised pins.
  // Acting on the level avoids any setup window tied to one link revision.
  wire sync_lvl = sync_sh_r[1];
  wire sync_rise = sync_lvl && !sync_d_r;
  wire sync_fall = !sync_lvl && sync_d_r;
  wire sref_rise = sref_sh_r[1] && !sref_d_r;

  // ==========================================================================
  // Local multiframe / extended multiblock counter
  // One counter serves both codings; only the system reference sets phase.
  logic [MF_LEN_W-1:0] lmfc_cnt_r;
  logic [MF_LEN_W-1:0] lmfc_cnt_nxt;
  wire mf_last = (lmfc_cnt_r == mf_len - 1'b1);

  always_comb begin
    if (sref_rise) begin
      lmfc_cnt_nxt = LMFC_CNT_RST;
    end else if (mf_last) begin
      lmfc_cnt_nxt = LMFC_CNT_RST;
    end else begin
      lmfc_cnt_nxt = lmfc_cnt_r + 1'b1;
    end
  end

  // Counter register; running from the device clock alone.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lmfc_cnt_r <= LMFC_CNT_RST;
    end else begin
      lmfc_cnt_r <= lmfc_cnt_nxt;
    end
  end

  // Subclass 1 timing: the multiframe edge is the deterministic reference.
  wire lmfc_hit = (lmfc_cnt_r == LMFC_CNT_RST);
  assign lmfc_edge = lmfc_hit;

  // ==========================================================================
  // Link state machine
  // All lanes share this one machine, so they start alignment together.
  link_state_t state_r;
  link_state_t state_nxt;
  logic [1:0] ilas_mf_r;
  logic [1:0] ilas_mf_nxt;

  always_comb begin
    state_nxt = state_r;
    ilas_mf_nxt = ilas_mf_r;
    if (mode_64b) begin
      // Block alignment comes from headers, so sync is not consulted.
      state_nxt = ST_DATA;
    end else if (!sync_lvl) begin
      state_nxt = ST_CGS;
    end else begin
      case (state_r)
        ST_CGS: begin
          if (sync_rise) begin
            state_nxt = ST_WAIT_LMFC;
          end
        end
        ST_WAIT_LMFC: begin
          // The edge is seen as the counter wraps into position zero.
          if (mf_last) begin
            state_nxt = ST_ILAS;
            ilas_mf_nxt = ILAS_MF_RST;
          end
        end
        ST_ILAS: begin
          if (mf_last) begin
            ilas_mf_nxt = ilas_mf_r + 1'b1;
            if (ilas_mf_r == ILAS_MF_LAST) begin
              state_nxt = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          state_nxt = ST_DATA;
        end
        default: begin
          state_nxt = ST_CGS;
        end
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_CGS;
      ilas_mf_r <= ILAS_MF_RST;
    end else begin
      state_r <= state_nxt;
      ilas_mf_r <= ilas_mf_nxt;
    end
  end

  // ==========================================================================
  // Sample FIFO
  // Samples only drain while user data is flowing; during start-up the FIFO
  // fills and its ready stalls the source.
  logic [LANES*8-1:0] fifo_data;
  logic fifo_valid;
  wire sending = (state_r == ST_DATA);
  wire fifo_pop = sending;

  sample_fifo #(
    .WIDTH(LANES * 8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ==========================================================================
  // Character selection
  // Octet for one lane in the current cycle, before line encoding.
  function automatic logic [8:0] pick_char(
    input link_state_t st,
    input logic first,
    input logic last,
    input logic [1:0] mf,
    input logic [MF_LEN_W-1:0] pos,
    input logic [7:0] cfg,
    input logic [7:0] dat
  );
    logic [8:0] c;
    c = {1'b0, CHAR_IDLE};
    case (st)
      ST_CGS: c = {1'b1, CHAR_COMMA};
      ST_WAIT_LMFC: c = {1'b1, CHAR_COMMA};
      ST_ILAS: begin
        if (first) begin
          c = {1'b1, CHAR_MF_START};
        end else if (last) begin
          c = {1'b1, CHAR_MF_END};
        end else if (mf == 2'h1 && pos == 10'h001) begin
          c = {1'b0, cfg};
        end else begin
          c = {1'b0, pos[7:0]};
        end
      end
      ST_DATA: c = {1'b0, dat};
      default: c = {1'b1, CHAR_COMMA};
    endcase
    return c;
  endfunction : pick_char

  // Configuration octet carried in the second alignment multiframe.
  wire [7:0] cfg_octet = {2'h0, mode_64b, lanes_used};
  wire [LANES*8-1:0] data_src = fifo_valid ? fifo_data : '0;

  logic [LANES*8-1:0] octet_nxt;
  logic [LANES-1:0] k_nxt;
  logic [LANES-1:0] en_nxt;

  always_comb begin
    logic [8:0] ch;
    ch = '0;
    octet_nxt = '0;
    k_nxt = '0;
    en_nxt = '0;
    for (int i = 0; i < LANES; i++) begin
      // Lanes past the configured count stay quiet.
      if (5'(i) < lanes_used) begin
        ch = pick_char(state_r, lmfc_hit, mf_last, ilas_mf_r, lmfc_cnt_r,
                       cfg_octet, data_src[i*8 +: 8]);
        octet_nxt[i*8 +: 8] = ch[7:0];
        k_nxt[i] = ch[8] && !mode_64b;
        en_nxt[i] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // 64B/66B block framing and parity
  // Block position follows the extended multiblock counter, so a system
  // reference realigns blocks too; mf_len must be a multiple of eight here.
  wire [2:0] blk_pos = lmfc_cnt_r[2:0];
  wire blk_first = mode_64b && (blk_pos == 3'h0);
  wire blk_last = mode_64b && (blk_pos == BLOCK_LAST);
  logic [LANES*8-1:0] par_acc_r;
  wire [LANES*8-1:0] par_seed = blk_first ? '0 : par_acc_r;
  wire [LANES*8-1:0] par_nxt = par_seed ^ octet_nxt;

  // Output registers for characters, headers and parity.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_octet <= '0;
      lane_is_k <= '0;
      lane_en <= '0;
      hdr_valid <= 1'b0;
      hdr <= 2'h0;
      par_acc_r <= '0;
      fec_parity <= '0;
      fec_valid <= 1'b0;
    end else begin
      lane_octet <= octet_nxt;
      lane_is_k <= k_nxt;
      lane_en <= en_nxt;
      // Header is always plain data; no check bits are folded into it.
      hdr_valid <= blk_first;
      hdr <= HDR_DATA;
      par_acc_r <= par_nxt;
      fec_valid <= blk_last && fec_en;
      if (blk_last && fec_en) begin
        fec_parity <= par_nxt;
      end
    end
  end

  // ==========================================================================
  // Status and oscillator trigger
  // In 64B/66B the sync pin's falling edge is passed on as a one-cycle
  // trigger for the oscillators instead of restarting the link.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_up <= 1'b0;
      nco_sync <= 1'b0;
    end else begin
      link_up <= (state_nxt == ST_DATA);
      nco_sync <= mode_64b && sync_fall;
    end
  end

endmodule : serial_converter_link_tx

/* File: tb/link_tx_props.sv */
// Purpose: Port-level checks of the link transmitter.
// Assumes: Configuration inputs stay static between resets.
// Notes: Bound into every instance of the top module.
`timescale 1ns/1ps
module link_tx_props
  import link_tx_pkg::*;
#(
  parameter int LANES = MAX_LANES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic sysref,
  input wire logic mode_64b,
  input wire logic fec_en,
  input wire logic [LANES*8-1:0] lane_octet,
  input wire logic [LANES-1:0] lane_is_k,
  input wire logic hdr_valid,
  input wire logic [1:0] hdr,
  input wire logic fec_valid,
  input wire logic lmfc_edge,
  input wire logic nco_sync
);
  // ==========================================================================
  // Assertions
  // One clock domain, so clocking and reset are shared by all checks.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_hdr_data: assert property (hdr_valid |-> hdr == HDR_DATA)
    else $error("block header is not the data header");
  chk_hdr_mode: assert property (hdr_valid |-> mode_64b)
    else $error("block header outside block coding");
  chk_fec_gate: assert property (fec_valid |-> mode_64b && fec_en)
    else $error("parity pulse without parity enabled");
  chk_fec_block: assert property (hdr_valid && fec_en && mode_64b |-> ##7 fec_valid)
    else $error("parity not on last octet of block");
  chk_no_k_64b: assert property (mode_64b |-> lane_is_k == '0)
    else $error("control character in block coding");
  // Five low samples cover the two synchroniser flops plus state and output.
  chk_comma_sync: assert property ((!mode_64b && !sync_n) [*5]
    |-> lane_octet[7:0] == CHAR_COMMA && lane_is_k[0])
    else $error("no comma while sync is low");
  chk_sysref_phase: assert property ($rose(sysref) |-> ##[1:6] lmfc_edge)
    else $error("reference edge did not realign the counter");
  chk_nco_pulse: assert property (nco_sync |-> mode_64b ##1 !nco_sync)
    else $error("oscillator sync pulse malformed");
endmodule : link_tx_props

bind serial_converter_link_tx link_tx_props #(.LANES(LANES)) i_props (
  .clk(clk), .rst_n(rst_n), .sync_n(sync_n), .sysref(sysref), .mode_64b(mode_64b),
  .fec_en(fec_en), .lane_octet(lane_octet), .lane_is_k(lane_is_k), .hdr_valid(hdr_valid),
  .hdr(hdr), .fec_valid(fec_valid), .lmfc_edge(lmfc_edge), .nco_sync(nco_sync));

/* File: tb/link_rx_model.sv */
// Purpose: Receiving logic device side of the sync handshake.
// Assumes: Lane 0 is watched for the comma stream.
// Notes: Frees sync_n after four commas on a multiframe edge, or as soon as req drops.
`timescale 1ns/1ps
module link_rx_model
  import link_tx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [7:0] octet0,
  input wire logic k0,
  input wire logic lmfc_edge,
  output logic sync_n,
  output logic [3:0] commas_r
);
  logic req_r;
  // ==========================================================================
  // Handshake
  // sync_n is a level held over many edges, which both older revisions accept.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_n <= 1'b1;
      req_r <= 1'b0;
      commas_r <= 4'h0;
    end else begin
      req_r <= req;
      if (req && !req_r) begin
        sync_n <= 1'b0;
        commas_r <= 4'h0;
      end else if (!sync_n && octet0 == CHAR_COMMA && k0 && commas_r != 4'hf) begin
        commas_r <= commas_r + 4'h1;
      end
      if (!req || (!sync_n && commas_r >= 4'h4 && lmfc_edge)) begin
        sync_n <= 1'b1;
      end
    end
  end
endmodule : link_rx_model

/* File: tb/serial_converter_link_tx_tb.sv */
// Purpose: Self-checking bench for the link transmitter.
// Assumes: Two lanes, multiframe of eight octets.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/1ps
module serial_converter_link_tx_tb;
  import link_tx_pkg::*;
  localparam int LN = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sysref = 1'b0;
  logic mode_64b = 1'b0;
  logic fec_en = 1'b0;
  logic in_valid = 1'b0;
  logic req = 1'b0;
  logic [4:0] lanes_used = 5'h02;
  logic [MF_LEN_W-1:0] mf_len = 10'h008;
  logic [LN*8-1:0] in_data = 16'h0000;
  logic sync_n, in_ready, hdr_valid, fec_valid, link_up, lmfc_edge, nco_sync;
  logic [LN*8-1:0] lane_octet, fec_parity;
  logic [LN-1:0] lane_is_k, lane_en;
  logic [1:0] hdr;
  logic [3:0] commas;
  logic [7:0] acc;
  int failures = 0;
  int tests_run = 0;
  int n;

  // ==========================================================================
  // Clock, design and far side
  always #4 clk = ~clk;
  serial_converter_link_tx #(.LANES(LN), .FIFO_DEPTH(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .sync_n(sync_n), .sysref(sysref), .mode_64b(mode_64b),
    .fec_en(fec_en), .lanes_used(lanes_used), .mf_len(mf_len), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .lane_octet(lane_octet),
    .lane_is_k(lane_is_k), .lane_en(lane_en), .hdr_valid(hdr_valid), .hdr(hdr),
    .fec_parity(fec_parity), .fec_valid(fec_valid), .link_up(link_up),
    .lmfc_edge(lmfc_edge), .nco_sync(nco_sync));
  link_rx_model i_rx (.clk(clk), .rst_n(rst_n), .req(req), .octet0(lane_octet[7:0]),
    .k0(lane_is_k[0]), .lmfc_edge(lmfc_edge), .sync_n(sync_n), .commas_r(commas));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic m64, input logic [4:0] lu);
    @(negedge clk);
    rst_n = 1'b0;
    req = 1'b0;
    in_valid = 1'b0;
    mode_64b = m64;
    fec_en = m64;
    lanes_used = lu;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  // ==========================================================================
  // Scenarios
  // Fill the buffer while commas go out, bring the link up, then re-request.
  task automatic t_link_8b();
    int i;
    do_reset(1'b0, 5'h02);
    sysref = 1'b1;
    repeat (2) @(negedge clk);
    sysref = 1'b0;
    acc = 8'h00;
    repeat (10) begin
      in_valid = 1'b1;
      in_data = {8'h20 + acc, 8'h10 + acc};
      #1;
      if (in_ready) acc++;
      @(negedge clk);
    end
    in_valid = 1'b0;
    check(acc, 8);
    req = 1'b1;
    n = 0;
    while (commas < 4'h4 && n < 60) begin @(negedge clk); n++; end
    check(commas >= 4'h4, 1'b1);
    check({lane_is_k, lane_octet}, {2'b11, CHAR_COMMA, CHAR_COMMA});
    n = 0;
    while (lane_octet[7:0] === CHAR_COMMA && n < 100) begin @(negedge clk); n++; end
    check({lane_is_k[0], lane_octet[7:0]}, {1'b1, CHAR_MF_START});
    n = 0;
    while (!link_up && n < 200) begin @(negedge clk); n++; end
    // Link up follows the state, one cycle ahead of the registered lane octets,
    // so the last alignment character still stands when it rises.
    check(n, 4 * mf_len - 1);
    check({lane_is_k[0], lane_octet[7:0]}, {1'b1, CHAR_MF_END});
    @(negedge clk);
    for (i = 0; i < 8; i++) begin
      n = 0;
      while (lane_octet[7:0] === 8'h00 && n < 20) begin @(negedge clk); n++; end
      check(lane_octet, {8'h20 + i[7:0], 8'h10 + i[7:0]});
      @(negedge clk);
    end
    req = 1'b0;
    @(negedge clk);
    req = 1'b1;
    repeat (6) @(negedge clk);
    check(link_up, 1'b0);
    check({lane_is_k, lane_octet}, {2'b11, CHAR_COMMA, CHAR_COMMA});
    req = 1'b0;
  endtask : t_link_8b

  // Block coding: one lane, parity over a block, sync only for the oscillators.
  task automatic t_64b();
    int i;
    do_reset(1'b1, 5'h01);
    @(negedge clk);
    check(lane_en, 2'b01);
    in_valid = 1'b1;
    repeat (8) begin
      in_data = in_data + 16'h0301;
      @(negedge clk);
    end
    in_valid = 1'b0;
    n = 0;
    while (!hdr_valid && n < 20) begin @(negedge clk); n++; end
    check(hdr_valid, 1'b1);
    acc = 8'h00;
    for (i = 0; i < 8; i++) begin
      acc = acc ^ lane_octet[7:0];
      if (i < 7) @(negedge clk);
    end
    check(fec_valid, 1'b1);
    check(fec_parity[7:0], acc);
    n = 0;
    req = 1'b1;
    repeat (8) begin @(negedge clk); n += nco_sync; end
    check(n, 1);
    check(link_up, 1'b1);
    check(lane_is_k, 2'b00);
    req = 1'b0;
  endtask : t_64b

  // ==========================================================================
  // Run control
  task automatic end_sim();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // The whole run needs well under a thousand cycles; this bound cuts a hang.
  initial begin
    #100000;
    failures++;
    end_sim();
  end

  initial begin
    t_link_8b();
    $display("test link_8b done");
    t_64b();
    $display("test block_64b done");
    end_sim();
  end
endmodule : serial_converter_link_tx_tb
